//--- core/tsdm_pkg.sv
`default_nettype none
package tsdm_pkg;
    localparam int AXIS_W = 11;
    localparam int TEMP_W = 8;
    localparam int CMD_W = 8;
    localparam int ACC_W = 16;
    localparam int ACC_FRAC = 12;
    localparam int AXIS_ZERO = 1024;
    localparam int AXIS_MAX = 2047;
    localparam int SENS_NARROW = 1638;
    localparam int SENS_WIDE = 819;
    localparam int FAULT_LIMIT = 102;
    localparam logic [10:0] AXIS_FAULT_LOW = 11'h000;
    localparam logic [7:0] TEMP_FAULT_LOW = 8'h00;
    localparam logic [7:0] MEASURE_MODE_CMD = 8'h00;
    localparam logic [7:0] READ_TEMPERATURE_CMD = 8'h08;
    localparam logic [7:0] SELFTEST_X_CMD = 8'h0E;
    localparam logic [7:0] SELFTEST_Y_CMD = 8'h0F;
    localparam logic [7:0] READ_X_AXIS_CMD = 8'h10;
    localparam logic [7:0] READ_Y_AXIS_CMD = 8'h11;
    localparam int RELOAD_TIME_US = 150;
    localparam int CLK_FREQ_MHZ = 100;
    localparam int RELOAD_CYCLES = RELOAD_TIME_US * CLK_FREQ_MHZ;
    localparam int CAL_W = 16;
    localparam int SYNC_W = 5;
    localparam logic [4:0] SYNC_RESET = 5'h01;

    typedef enum logic [4:0] {
        CAL_INIT   = 5'h01,
        CAL_CHECK  = 5'h02,
        CAL_RELOAD = 5'h04,
        CAL_VERIFY = 5'h08,
        CAL_FAULT  = 5'h10
    } tsdm_cal_state_t;
endpackage
`default_nettype wire

//--- core/tsdm_spi_link.sv
`timescale 1ns/1ps
`default_nettype none
module tsdm_spi_link (
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    input  wire logic [10:0] x_word,
    input  wire logic [10:0] y_word,
    input  wire logic [7:0]  t_word,
    output logic             miso,
    output logic             miso_oe,
    output logic [7:0]       cmd_word,
    output logic             cmd_vld
);
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q;
    logic [7:0]  cmd_q;
    logic        vld_q;
    logic [10:0] tx_q;
    logic        oe_q;
    logic        is_read;
    logic [10:0] word;

    // Chip select high clears the frame, so no SCK edge is needed after it.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            cmd_q <= 8'h00;
            vld_q <= 1'b0;
        end else begin
            if (cnt_q != 4'hF) begin
                cnt_q <= cnt_q + 4'h1;
            end
            sh_q <= {sh_q[6:0], mosi};
            if (cnt_q == 4'h7) begin
                cmd_q <= {sh_q[6:0], mosi};
                vld_q <= 1'b1;
            end
        end
    end

    always_comb begin
        is_read = 1'b1;
        word = x_word;
        case (cmd_q)
            tsdm_pkg::READ_X_AXIS_CMD: word = x_word;
            tsdm_pkg::READ_Y_AXIS_CMD: word = y_word;
            tsdm_pkg::READ_TEMPERATURE_CMD: word = {t_word, 3'h0};
            default: is_read = 1'b0;
        endcase
    end

    // Unknown commands leave the output undriven until the next frame.
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            tx_q <= 11'h000;
            oe_q <= 1'b0;
        end else if (vld_q && !oe_q && is_read) begin
            tx_q <= word;
            oe_q <= 1'b1;
        end else if (oe_q) begin
            tx_q <= {tx_q[9:0], 1'b0};
        end
    end

    assign miso = tx_q[10];
    assign miso_oe = oe_q;
    assign cmd_word = cmd_q;
    assign cmd_vld = vld_q;
endmodule
`default_nettype wire

//--- core/tsdm_cal_parity.sv
`timescale 1ns/1ps
`default_nettype none
module tsdm_cal_parity (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [16:0] nvm_word,
    input  wire logic        we,
    input  wire logic [16:0] wdata,
    output logic [15:0]      cal_word,
    output logic             fault
);
    tsdm_pkg::tsdm_cal_state_t state_q;
    logic [16:0] cal_q;
    logic        par_ok;

    // Even parity over data and parity bit together.
    assign par_ok = ~^cal_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= tsdm_pkg::CAL_INIT;
        end else begin
            case (state_q)
                tsdm_pkg::CAL_INIT: state_q <= tsdm_pkg::CAL_CHECK;
                tsdm_pkg::CAL_CHECK: begin
                    if (!par_ok) begin
                        state_q <= tsdm_pkg::CAL_RELOAD;
                    end
                end
                tsdm_pkg::CAL_RELOAD: state_q <= tsdm_pkg::CAL_VERIFY;
                tsdm_pkg::CAL_VERIFY: begin
                    state_q <= par_ok ? tsdm_pkg::CAL_CHECK
                                      : tsdm_pkg::CAL_FAULT;
                end
                tsdm_pkg::CAL_FAULT: state_q <= tsdm_pkg::CAL_FAULT;
                default: state_q <= tsdm_pkg::CAL_INIT;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cal_q <= 17'h00000;
        end else if (state_q == tsdm_pkg::CAL_INIT ||
                     state_q == tsdm_pkg::CAL_RELOAD) begin
            cal_q <= nvm_word;
        end else if (we && state_q == tsdm_pkg::CAL_CHECK) begin
            cal_q <= wdata;
        end
    end

    assign cal_word = cal_q[15:0];
    assign fault = (state_q == tsdm_pkg::CAL_FAULT);

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence reload_seq;
        (state_q == tsdm_pkg::CAL_RELOAD) ##1 (state_q == tsdm_pkg::CAL_VERIFY);
    endsequence

    parity_reload_a:
        assert property ((state_q == tsdm_pkg::CAL_CHECK && !par_ok)
                         |=> reload_seq)
        else $error("Parity error did not start a reload.");
    second_error_a:
        assert property ((state_q == tsdm_pkg::CAL_CHECK && !par_ok)
                         ##2 !par_ok |=> fault)
        else $error("Repeated parity error did not raise the fault.");
    fault_held_a:
        assert property ($rose(fault) |=> fault [*8])
        else $error("Parity fault did not stay set.");
endmodule
`default_nettype wire

//--- core/tsdm_top.sv
// Summary of operation
// - Each axis word is unsigned 11 bits, clamped to its valid span.
// - Zero tilt gives axis word 1024, only the top bit set.
// - Axis word moves 1638 or 819 counts per g, by variant.
// - Sensing element interconnect failure forces both axis words near ground, not temperature.
// - Calibration register parity is checked every cycle until a fault is set, reloaded on error.
// - A parity error after reload forces data below 102 counts.
// - Self-test drives that channel's word to its maximum.
// - Self-test command enters self-test, measure command leaves it.
// - A high self-test pin also enters self-test for its channel.
// - After self-test ends the word returns to the measured value.
// - Temperature is an unsigned 8-bit word readable over serial.
// - Codes: measure 00h, X self-test 0Eh, Y self-test 0Fh.
// - Codes: read X 10h, read Y 11h, read temperature 08h.
// - Data reloads every 150 us, never while chip select is low.
// - Axis word shifts out MSB first, 11 bits after the command.
`timescale 1ns/1ps
`default_nettype none
module tsdm_top #(
    parameter bit WIDE_RANGE    = 1'b0,
    parameter int RELOAD_CYCLES = tsdm_pkg::RELOAD_CYCLES
) (
    input  wire logic               CLK,
    input  wire logic               RST,
    input  wire logic               SCK,
    input  wire logic               CHIP_SELECT_N,
    input  wire logic               MOSI,
    output logic                    MISO,
    output logic                    MISO_OE,
    input  wire logic signed [15:0] ACC_X,
    input  wire logic signed [15:0] ACC_Y,
    input  wire logic [7:0]         TEMP_RAW,
    input  wire logic               ELEMENT_FAULT,
    input  wire logic               SELFTEST_X_PIN,
    input  wire logic               SELFTEST_Y_PIN,
    input  wire logic [16:0]        NVM_CAL,
    input  wire logic               CAL_WE,
    input  wire logic [16:0]        CAL_WDATA,
    output logic                    SELFTEST_X,
    output logic                    SELFTEST_Y,
    output logic [15:0]             CAL_WORD,
    output logic                    PARITY_FAULT,
    output logic [10:0]             X_WORD,
    output logic [10:0]             Y_WORD,
    output logic [7:0]              TEMP_WORD
);
    localparam int SENS = WIDE_RANGE ? tsdm_pkg::SENS_WIDE
                                     : tsdm_pkg::SENS_NARROW;
    localparam int RW = $clog2(RELOAD_CYCLES + 1);
    localparam logic [10:0] ZERO_WORD = 11'(tsdm_pkg::AXIS_ZERO);
    localparam logic [10:0] MAX_WORD = 11'(tsdm_pkg::AXIS_MAX);

    logic [4:0]    meta_q;
    logic [4:0]    sync_q;
    logic          cs_idle;
    logic          elem_fault;
    logic          pin_x;
    logic          pin_y;
    logic          cmd_vld_s;
    logic          cmd_seen_q;
    logic          cmd_take;
    logic [7:0]    cmd_word;
    logic          cmd_vld;
    logic          st_x_cmd_q;
    logic          st_y_cmd_q;
    logic          st_x_q;
    logic          st_y_q;
    logic [RW-1:0] cnt_q;
    logic          load_en;
    logic          par_fault;
    logic [10:0]   x_d;
    logic [10:0]   y_d;
    logic [7:0]    t_d;
    logic [10:0]   x_q;
    logic [10:0]   y_q;
    logic [7:0]    t_q;
    logic          miso_i;
    logic          miso_oe_i;

    // Maps acceleration in g, with ACC_FRAC fraction bits, to the output
    // word. The span is clamped so an overrange input cannot wrap.
    function automatic logic [10:0] tsdm_scale(
        input logic signed [15:0] acc
    );
        logic signed [31:0] v;
        v = (32'(acc) * SENS) >>> tsdm_pkg::ACC_FRAC;
        v = v + tsdm_pkg::AXIS_ZERO;
        if (v < 0) begin
            return 11'h000;
        end else if (v > tsdm_pkg::AXIS_MAX) begin
            return MAX_WORD;
        end else begin
            return 11'(v);
        end
    endfunction

    // Serial side runs entirely on the host's clock.
    tsdm_spi_link u_link (
        .sck      (SCK),
        .cs_n     (CHIP_SELECT_N),
        .mosi     (MOSI),
        .x_word   (x_q),
        .y_word   (y_q),
        .t_word   (t_q),
        .miso     (miso_i),
        .miso_oe  (miso_oe_i),
        .cmd_word (cmd_word),
        .cmd_vld  (cmd_vld)
    );

    tsdm_cal_parity u_cal (
        .clk      (CLK),
        .rst      (RST),
        .nvm_word (NVM_CAL),
        .we       (CAL_WE),
        .wdata    (CAL_WDATA),
        .cal_word (CAL_WORD),
        .fault    (par_fault)
    );

    // Chip select, the fault and self-test pins and the link's command flag pass two flip-flops here.
    // Chip select resets to its idle level, so no false edge follows reset.
    always_ff @(posedge CLK) begin
        if (RST) begin
            meta_q <= tsdm_pkg::SYNC_RESET;
            sync_q <= tsdm_pkg::SYNC_RESET;
        end else begin
            meta_q <= {cmd_vld, SELFTEST_Y_PIN, SELFTEST_X_PIN,
                       ELEMENT_FAULT, CHIP_SELECT_N};
            sync_q <= meta_q;
        end
    end

    assign cs_idle = sync_q[0];
    assign elem_fault = sync_q[1];
    assign pin_x = sync_q[2];
    assign pin_y = sync_q[3];
    assign cmd_vld_s = sync_q[4];

    always_ff @(posedge CLK) begin
        if (RST) begin
            cmd_seen_q <= 1'b0;
        end else begin
            cmd_seen_q <= cmd_vld_s;
        end
    end

    // The command byte is held still by the link while its flag is up,
    // so it is safe to read once the synchronised flag has risen.
    assign cmd_take = cmd_vld_s && !cmd_seen_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_x_cmd_q <= 1'b0;
            st_y_cmd_q <= 1'b0;
        end else if (cmd_take) begin
            case (cmd_word)
                tsdm_pkg::MEASURE_MODE_CMD: begin
                    st_x_cmd_q <= 1'b0;
                    st_y_cmd_q <= 1'b0;
                end
                tsdm_pkg::SELFTEST_X_CMD: begin
                    st_x_cmd_q <= 1'b1;
                end
                tsdm_pkg::SELFTEST_Y_CMD: begin
                    st_y_cmd_q <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Both channels are not blocked from self-test at once; the host is
    // trusted not to request it.
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_x_q <= 1'b0;
            st_y_q <= 1'b0;
        end else begin
            st_x_q <= st_x_cmd_q || pin_x;
            st_y_q <= st_y_cmd_q || pin_y;
        end
    end

    // The interval restarts whenever chip select is low, so a fresh load
    // is only seen after a full interval of idle bus.
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_q <= '0;
        end else if (!cs_idle) begin
            cnt_q <= '0;
        end else if (cnt_q == RW'(RELOAD_CYCLES - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + RW'(1);
        end
    end

    assign load_en = cs_idle && (cnt_q == RW'(RELOAD_CYCLES - 1));

    always_comb begin
        x_d = tsdm_scale(ACC_X);
        y_d = tsdm_scale(ACC_Y);
        t_d = TEMP_RAW;
        // Parity fault outranks the interconnect check: bad calibration
        // makes every word suspect, the temperature included.
        if (par_fault) begin
            x_d = tsdm_pkg::AXIS_FAULT_LOW;
            y_d = tsdm_pkg::AXIS_FAULT_LOW;
            t_d = tsdm_pkg::TEMP_FAULT_LOW;
        end else if (elem_fault) begin
            x_d = tsdm_pkg::AXIS_FAULT_LOW;
            y_d = tsdm_pkg::AXIS_FAULT_LOW;
        end else begin
            if (st_x_q) begin
                x_d = MAX_WORD;
            end
            if (st_y_q) begin
                y_d = MAX_WORD;
            end
        end
    end

    // Words only change while chip select is high, which keeps them
    // still for the link during a frame.
    always_ff @(posedge CLK) begin
        if (RST) begin
            x_q <= ZERO_WORD;
            y_q <= ZERO_WORD;
            t_q <= 8'h00;
        end else if (load_en) begin
            x_q <= x_d;
            y_q <= y_d;
            t_q <= t_d;
        end
    end

    assign MISO = miso_i;
    assign MISO_OE = miso_oe_i;
    assign SELFTEST_X = st_x_q;
    assign SELFTEST_Y = st_y_q;
    assign PARITY_FAULT = par_fault;
    assign X_WORD = x_q;
    assign Y_WORD = y_q;
    assign TEMP_WORD = t_q;

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence plain_load_x;
        load_en && !par_fault && !elem_fault && !st_x_q;
    endsequence

    sequence st_x_cmd_seq;
        cmd_take && cmd_word == tsdm_pkg::SELFTEST_X_CMD;
    endsequence

    sequence st_y_cmd_seq;
        cmd_take && cmd_word == tsdm_pkg::SELFTEST_Y_CMD;
    endsequence

    zero_word_a:
        assert property (plain_load_x ##0 ACC_X == 16'sh0000
                         |=> x_q == 11'h400)
        else $error("Zero tilt did not give the mid-scale word.");
    half_g_a:
        assert property (plain_load_x ##0 ACC_X == 16'sh0800
                         |=> x_q == 11'(tsdm_pkg::AXIS_ZERO + SENS / 2))
        else $error("Half g did not give the expected word.");
    elem_force_a:
        assert property (load_en && elem_fault && !par_fault
                         |=> x_q == 11'h000 && y_q == 11'h000)
        else $error("Interconnect failure did not force the words low.");
    par_force_a:
        assert property (load_en && par_fault
                         |=> x_q < 11'(tsdm_pkg::FAULT_LIMIT)
                             && y_q < 11'(tsdm_pkg::FAULT_LIMIT))
        else $error("Parity fault did not force the words low.");
    selftest_max_a:
        assert property (load_en && st_x_q && !par_fault && !elem_fault
                         |=> x_q == 11'h7FF)
        else $error("Self-test did not drive the X word to maximum.");
    cmd_enter_a:
        assert property (st_x_cmd_seq |=> ##1 SELFTEST_X)
        else $error("Self-test command did not reach the output.");
    cmd_leave_a:
        assert property (cmd_take && cmd_word == 8'h00 && !pin_x
                         ##1 !pin_x |=> !SELFTEST_X)
        else $error("Measure command did not end self-test.");
    pin_enter_a:
        assert property (pin_x |=> SELFTEST_X)
        else $error("Self-test pin did not reach the output.");
    idle_reload_a:
        assert property ($rose(cs_idle) |-> !load_en [*8])
        else $error("Reload came too soon after chip select rose.");
    temp_pass_a:
        assert property (load_en && !par_fault |=> t_q == $past(TEMP_RAW))
        else $error("Temperature word was not loaded.");

    // The Y channel gets the same self-test checks as X, since a slip
    // between the two channels would pass the X checks alone.
    sty_enter_a:
        assert property (st_y_cmd_seq |=> ##1 SELFTEST_Y)
        else $error("Self-test command did not reach the Y output.");
    sty_leave_a:
        assert property (cmd_take && cmd_word == 8'h00 && !pin_y
                         ##1 !pin_y |=> !SELFTEST_Y)
        else $error("Measure command did not end Y self-test.");
    piny_enter_a:
        assert property (pin_y |=> SELFTEST_Y)
        else $error("Self-test pin did not reach the Y output.");
    stx_release_a:
        assert property (!st_x_cmd_q && !pin_x |=> !SELFTEST_X)
        else $error("X self-test stayed on with no request.");
    sty_release_a:
        assert property (!st_y_cmd_q && !pin_y |=> !SELFTEST_Y)
        else $error("Y self-test stayed on with no request.");
    sty_max_a:
        assert property (load_en && st_y_q && !par_fault && !elem_fault
                         |=> y_q == 11'h7FF)
        else $error("Self-test did not drive the Y word to maximum.");

    // A host in mid-frame must see still words, or it would read the top
    // and bottom bits of two different samples.
    frozen_words_a:
        assert property (!cs_idle |=> $stable(x_q) && $stable(y_q)
                                      && $stable(t_q))
        else $error("A data word changed while chip select was low.");
    par_temp_a:
        assert property (load_en && par_fault
                         |=> t_q < 8'(tsdm_pkg::FAULT_LIMIT))
        else $error("Parity fault did not force the temperature low.");
    fault_kept_a:
        assert property (PARITY_FAULT |=> PARITY_FAULT)
        else $error("Parity fault cleared without a reset.");
endmodule
`default_nettype wire

//--- testbench/tsdm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsdm_host_model (
    output var logic sck,
    output var logic cs_n,
    output var logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    // The serial clock stands still between frames, and a released data
    // line toggles so that a stale level can never pass for real data.
    // A MISO bit taken while the link drives nothing is seen inverted.
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        cs_n = 1'b0;
        // A rising chip select clears the link before the first frame.
        #1;
        cs_n = 1'b1;
    end

    task automatic xfer(input logic [7:0] cmd, input int nbits,
                        input int half, output logic [10:0] data,
                        output logic oe_seen);
        data = 11'h000;
        oe_seen = 1'b0;
        // Frames start off the system clock's edges so the clocks never tie.
        #3;
        cs_n = 1'b0;
        #(half);
        for (int i = 7; i >= 0; i--) begin
            mosi = cmd[i];
            #(half);
            sck = 1'b1;
            #(half);
            sck = 1'b0;
        end
        for (int j = 0; j < nbits; j++) begin
            mosi = ~mosi;
            #(half);
            sck = 1'b1;
            data = {data[9:0], miso_oe ? miso : ~miso};
            oe_seen = oe_seen | miso_oe;
            #(half);
            sck = 1'b0;
        end
        // Chip select stays low one half period more, so the command is
        // seen by the system clock before the frame closes.
        #(half);
        cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_tilt_sensor_data_selftest_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tilt_sensor_data_selftest_monitor;
    localparam int RELOAD = 50;
    localparam int LIMIT  = 40000;

    logic               clk        = 1'b0;
    logic               rst        = 1'b1;
    logic               sck;
    logic               cs_n;
    logic               mosi;
    logic               miso;
    logic               miso_oe;
    logic signed [15:0] acc_x      = 16'sh0000;
    logic signed [15:0] acc_y      = 16'sh0000;
    logic [7:0]         temp_raw   = 8'hA5;
    logic               elem_fault = 1'b0;
    logic               pin_x      = 1'b0;
    logic               pin_y      = 1'b0;
    logic [16:0]        nvm_cal    = 17'h11234;
    logic               cal_we     = 1'b0;
    logic [16:0]        cal_wdata  = 17'h00000;
    logic               selftest_x;
    logic               selftest_y;
    logic [15:0]        cal_word;
    logic               par_fault;
    logic [10:0]        x_word;
    logic [10:0]        y_word;
    logic [7:0]         temp_word;
    int                 err_count  = 0;
    int                 compares   = 0;
    int                 cycles     = 0;

    tsdm_top #(
        .WIDE_RANGE   (1'b0),
        .RELOAD_CYCLES(RELOAD)
    ) i_tsdm_top (
        .CLK           (clk),
        .RST           (rst),
        .SCK           (sck),
        .CHIP_SELECT_N (cs_n),
        .MOSI          (mosi),
        .MISO          (miso),
        .MISO_OE       (miso_oe),
        .ACC_X         (acc_x),
        .ACC_Y         (acc_y),
        .TEMP_RAW      (temp_raw),
        .ELEMENT_FAULT (elem_fault),
        .SELFTEST_X_PIN(pin_x),
        .SELFTEST_Y_PIN(pin_y),
        .NVM_CAL       (nvm_cal),
        .CAL_WE        (cal_we),
        .CAL_WDATA     (cal_wdata),
        .SELFTEST_X    (selftest_x),
        .SELFTEST_Y    (selftest_y),
        .CAL_WORD      (cal_word),
        .PARITY_FAULT  (par_fault),
        .X_WORD        (x_word),
        .Y_WORD        (y_word),
        .TEMP_WORD     (temp_word)
    );

    tsdm_host_model i_tsdm_host_model (
        .sck    (sck),
        .cs_n   (cs_n),
        .mosi   (mosi),
        .miso   (miso),
        .miso_oe(miso_oe)
    );

    always #5 clk = ~clk;

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            $display("[ERR] run_cycles exp %0d seen %0d", LIMIT - 1, LIMIT);
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask

    // Chip select is held high long enough for a fresh load before reading.
    task automatic rd(input logic [7:0] cmd, input int nb, input int half,
                      output logic [10:0] d, output logic oe);
        repeat (RELOAD + 8) @(posedge clk);
        i_tsdm_host_model.xfer(cmd, nb, half, d, oe);
    endtask

    task automatic send(input logic [7:0] cmd);
        logic [10:0] d;
        logic        oe;
        i_tsdm_host_model.xfer(cmd, 0, 40, d, oe);
        repeat (8) @(posedge clk);
    endtask

    task automatic axes(input logic signed [15:0] ax,
                        input logic signed [15:0] ay,
                        input int ex, input int ey, input int et);
        logic [10:0] d;
        logic        oe;
        @(posedge clk);
        acc_x <= ax;
        acc_y <= ay;
        rd(tsdm_pkg::READ_X_AXIS_CMD, 11, 40, d, oe);
        chk("x_read", 16'(d), 16'(ex));
        chk("x_oe", 16'(oe), 16'h0001);
        chk("x_port", 16'(x_word), 16'(ex));
        rd(tsdm_pkg::READ_Y_AXIS_CMD, 11, 40, d, oe);
        chk("y_read", 16'(d), 16'(ey));
        chk("y_port", 16'(y_word), 16'(ey));
        rd(tsdm_pkg::READ_TEMPERATURE_CMD, 8, 40, d, oe);
        chk("t_read", 16'(d), 16'(et));
        chk("t_port", 16'(temp_word), 16'(et));
    endtask

    task automatic t_scale();
        int z;
        int h;
        real deg;
        z = tsdm_pkg::AXIS_ZERO;
        h = tsdm_pkg::SENS_NARROW / 2;
        axes(16'sh0000, 16'sh0000, z, z, 8'hA5);
        axes(16'sh0800, -16'sh0800, z + h, z - h, 8'hA5);
        axes(16'sh1000, -16'sh1000, tsdm_pkg::AXIS_MAX, 0, 8'hA5);
        // Host side: convert the raw word to degrees and trim its offset.
        deg = (real'(temp_word) - 197.0) / -1.083;
        chk("t_degc", 16'($rtoi(deg)), 16'h001D);
        chk("t_trim", 16'(temp_word - 8'hA5), 16'h0000);
        $display("test scale done");
    endtask

    task automatic t_selftest();
        int z;
        int m;
        z = tsdm_pkg::AXIS_ZERO;
        m = tsdm_pkg::AXIS_MAX;
        // Measure mode comes between the X and Y commands, and the pins are raised in turn, never both at once.
        send(tsdm_pkg::SELFTEST_X_CMD);
        chk("stx_on", 16'({selftest_y, selftest_x}), 16'h0001);
        axes(16'sh0000, 16'sh0000, m, z, 8'hA5);
        send(tsdm_pkg::MEASURE_MODE_CMD);
        chk("stx_off", 16'({selftest_y, selftest_x}), 16'h0000);
        send(tsdm_pkg::SELFTEST_Y_CMD);
        chk("sty_on", 16'({selftest_y, selftest_x}), 16'h0002);
        axes(16'sh0000, 16'sh0000, z, m, 8'hA5);
        send(tsdm_pkg::MEASURE_MODE_CMD);
        chk("sty_off", 16'({selftest_y, selftest_x}), 16'h0000);
        axes(16'sh0000, 16'sh0000, z, z, 8'hA5);
        // Pin pulses are scaled down from milliseconds to keep runs short.
        @(posedge clk);
        pin_x <= 1'b1;
        repeat (4) @(posedge clk);
        chk("pinx_on", 16'({selftest_y, selftest_x}), 16'h0001);
        axes(16'sh0000, 16'sh0000, m, z, 8'hA5);
        @(posedge clk);
        pin_x <= 1'b0;
        repeat (4) @(posedge clk);
        chk("pinx_off", 16'({selftest_y, selftest_x}), 16'h0000);
        pin_y <= 1'b1;
        repeat (4) @(posedge clk);
        chk("piny_on", 16'({selftest_y, selftest_x}), 16'h0002);
        pin_y <= 1'b0;
        repeat (4) @(posedge clk);
        chk("piny_off", 16'({selftest_y, selftest_x}), 16'h0000);
        $display("test selftest done");
    endtask

    task automatic t_faults();
        logic [10:0] d;
        logic        oe;
        i_tsdm_host_model.xfer(8'h55, 11, 40, d, oe);
        chk("bad_cmd_oe", 16'(oe), 16'h0000);
        rd(tsdm_pkg::READ_X_AXIS_CMD, 11, 40, d, oe);
        chk("reread", 16'(d), 16'(tsdm_pkg::AXIS_ZERO));
        @(posedge clk);
        elem_fault <= 1'b1;
        axes(16'sh0800, 16'sh0800, 0, 0, 8'hA5);
        @(posedge clk);
        elem_fault <= 1'b0;
        chk("cal_init", cal_word, 16'h1234);
        @(posedge clk);
        cal_we <= 1'b1;
        cal_wdata <= 17'h00001;
        @(posedge clk);
        cal_we <= 1'b0;
        repeat (6) @(posedge clk);
        chk("cal_reload", cal_word, 16'h1234);
        chk("no_fault", 16'(par_fault), 16'h0000);
        nvm_cal <= 17'h15678;
        cal_we <= 1'b1;
        @(posedge clk);
        cal_we <= 1'b0;
        repeat (6) @(posedge clk);
        chk("fault_set", 16'(par_fault), 16'h0001);
        nvm_cal <= 17'h11234;
        axes(16'sh0800, 16'sh0800, 0, 0, 0);
        chk("fault_kept", 16'(par_fault), 16'h0001);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("fault_clr", 16'(par_fault), 16'h0000);
        axes(16'sh0000, 16'sh0000, tsdm_pkg::AXIS_ZERO,
             tsdm_pkg::AXIS_ZERO, 8'hA5);
        $display("test faults done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_scale();
        t_selftest();
        t_faults();
        stop_test();
    end
endmodule
`default_nettype wire
